/* design/etd_dispatch.v */
`timescale 1ns/10ps
`include "etd_map.vh"
module etd_dispatch (
  // Clock and reset
  input wire core_clk,
  input wire reset_n,
  // Pending events, one bit per vector, per category
  input wire [255:0] trap_pend,
  input wire [255:0] ext_pend,
  input wire [255:0] fetch_pend,
  input wire [255:0] decode_pend,
  input wire [255:0] exec_pend,
  // Pipeline control
  input wire dispatch_req,
  input wire interrupt_return_instr,
  input wire [15:0] interrupt_table_limit,
  input wire virtual_mode_ext_bit,
  input wire v86_mode,
  input wire [31:0] redir_bitmap_word,
  // Task state save
  input wire save_req,
  input wire save_32bit,
  input wire [15:0] sel_in,
  input wire [31:0] flags_register,
  // I/O permission check
  input wire io_chk_req,
  input wire [31:0] io_map_base,
  input wire [15:0] io_port,
  input wire [31:0] task_state_limit,
  // Dispatch results
  output reg disp_valid_r,
  output reg [7:0] disp_vector_r,
  output reg [2:0] disp_cat_r,
  output reg disp_redirect_r,
  output reg shutdown_r,
  output reg nmi_blocked_r,
  // Save and check results
  output reg save_valid_r,
  output reg [31:0] save_sel_r,
  output reg [31:0] save_flags_r,
  output reg io_gp_r,
  output reg [7:0] io_gp_vector_r
);
  // ********************************
  // Priority pick
  // ********************************
  function [8:0] lowest;
    input [255:0] v;
    integer i;
    begin
      lowest = 9'h000;
      for (i = 255; i >= 0; i = i - 1) begin
        if (v[i]) begin
          lowest = {1'b1, i[7:0]};
        end
      end
    end
  endfunction

  function beyond;
    input [7:0] vec;
    input [15:0] lim;
    reg [18:0] last;
    begin
      last = ({11'h000, vec} << `ETD_GATE_SHIFT) + {3'h0, `ETD_GATE_LAST};
      beyond = last > {3'h0, lim};
    end
  endfunction

  reg [255:0] ext_eff;
  reg [7:0] win_vec;
  reg [2:0] win_cat;
  reg win_any;
  wire [255:0] cat_pend [0:`ETD_CAT_COUNT-1];
  wire [8:0] cat_pick [0:`ETD_CAT_COUNT-1];
  genvar g;

  // Pending NMI stays held off while blocked
  always @* begin
    ext_eff = ext_pend;
    ext_eff[`ETD_VEC_NMI] = ext_pend[`ETD_VEC_NMI] & ~nmi_blocked_r;
  end

  // Slot index equals category code
  assign cat_pend[`ETD_CAT_TRAP] = trap_pend;
  assign cat_pend[`ETD_CAT_EXT] = ext_eff;
  assign cat_pend[`ETD_CAT_FETCH] = fetch_pend;
  assign cat_pend[`ETD_CAT_DECODE] = decode_pend;
  assign cat_pend[`ETD_CAT_EXEC] = exec_pend;

  // ********************************
  // Per-category pick
  // ********************************
  generate
    for (g = 0; g < `ETD_CAT_COUNT; g = g + 1) begin : g_pick
      assign cat_pick[g] = lowest(cat_pend[g]);
    end
  endgenerate

  // ********************************
  // Category order
  // ********************************
  always @* begin
    win_any = 1'b1;
    if (cat_pick[`ETD_CAT_TRAP][8]) begin
      win_vec = cat_pick[`ETD_CAT_TRAP][7:0];
      win_cat = `ETD_CAT_TRAP;
    end else if (cat_pick[`ETD_CAT_EXT][8]) begin
      win_vec = cat_pick[`ETD_CAT_EXT][7:0];
      win_cat = `ETD_CAT_EXT;
    end else if (cat_pick[`ETD_CAT_FETCH][8]) begin
      win_vec = cat_pick[`ETD_CAT_FETCH][7:0];
      win_cat = `ETD_CAT_FETCH;
    end else if (cat_pick[`ETD_CAT_DECODE][8]) begin
      win_vec = cat_pick[`ETD_CAT_DECODE][7:0];
      win_cat = `ETD_CAT_DECODE;
    end else if (cat_pick[`ETD_CAT_EXEC][8]) begin
      win_vec = cat_pick[`ETD_CAT_EXEC][7:0];
      win_cat = `ETD_CAT_EXEC;
    end else begin
      win_vec = 8'h00;
      win_cat = `ETD_CAT_NONE;
      win_any = 1'b0;
    end
  end

  // Redirection bit for the vector, bitmap word supplied by the fetch side
  wire redir_hit = virtual_mode_ext_bit & v86_mode & redir_bitmap_word[win_vec[4:0]];
  // No address wrap: full 33-bit sum
  wire [32:0] io_end = {1'b0, io_map_base} + {17'h00000, io_port};
  // Entry limit checks for the winner and for the double-fault entry
  wire win_over = beyond(win_vec, interrupt_table_limit);
  wire df_over = beyond(`ETD_VEC_DF, interrupt_table_limit);

  // ********************************
  // NMI mask
  // ********************************
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_blocked_r <= 1'b0;
    end else begin
      // Return unblocks; a new NMI in the same cycle wins
      if (interrupt_return_instr) begin
        nmi_blocked_r <= 1'b0;
      end
      if (dispatch_req && win_any && !shutdown_r && win_cat == `ETD_CAT_EXT &&
          win_vec == `ETD_VEC_NMI) begin
        nmi_blocked_r <= 1'b1;
      end
    end
  end

  // ********************************
  // Dispatch state
  // ********************************
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      disp_valid_r <= 1'b0;
      disp_vector_r <= 8'h00;
      disp_cat_r <= `ETD_CAT_NONE;
      disp_redirect_r <= 1'b0;
      shutdown_r <= 1'b0;
    end else begin
      disp_valid_r <= 1'b0;
      disp_redirect_r <= 1'b0;
      // Shutdown is sticky until reset: nothing more is dispatched
      if (dispatch_req && win_any && !shutdown_r) begin
        // Double-fault path never redirects
        if (win_over) begin
          if (df_over) begin
            shutdown_r <= 1'b1;
          end else begin
            disp_valid_r <= 1'b1;
            disp_vector_r <= `ETD_VEC_DF;
            disp_cat_r <= win_cat;
          end
        end else begin
          disp_valid_r <= 1'b1;
          disp_vector_r <= win_vec;
          disp_cat_r <= win_cat;
          disp_redirect_r <= redir_hit;
        end
      end
    end
  end

  // ********************************
  // Task state save and I/O check
  // ********************************
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      save_valid_r <= 1'b0;
      save_sel_r <= 32'h00000000;
      save_flags_r <= 32'h00000000;
      io_gp_r <= 1'b0;
      io_gp_vector_r <= 8'h00;
    end else begin
      save_valid_r <= save_req;
      if (save_req) begin
        save_sel_r <= {`ETD_SEL_HI_ZERO, sel_in};
        if (save_32bit) begin
          save_flags_r <= flags_register;
        end else begin
          save_flags_r <= {`ETD_FLAGS_HI_ZERO, flags_register[15:0]};
        end
      end
      // Bases under the recommended ceiling still fault here once base plus port passes task_state_limit
      io_gp_r <= io_chk_req && (io_end > {1'b0, task_state_limit});
      io_gp_vector_r <= `ETD_VEC_GP;
    end
  end
endmodule // etd_dispatch

/* design/etd_map.vh */
`ifndef ETD_MAP_VH
`define ETD_MAP_VH
// ********************************
// Category and vector constants
// ********************************
`define ETD_CAT_TRAP 3'h0
`define ETD_CAT_EXT 3'h1
`define ETD_CAT_FETCH 3'h2
`define ETD_CAT_DECODE 3'h3
`define ETD_CAT_EXEC 3'h4
`define ETD_CAT_NONE 3'h7
`define ETD_CAT_COUNT 5
`define ETD_VEC_NMI 8'h02
`define ETD_VEC_DF 8'h08
`define ETD_VEC_GP 8'h0D
`define ETD_GATE_SHIFT 3
`define ETD_GATE_LAST 16'h0007
`define ETD_SEL_HI_ZERO 16'h0000
`define ETD_FLAGS_HI_ZERO 16'h0000
`define ETD_IOMAP_REC_MAX 32'h0000DFFF
`endif

/* testbench/etd_chk_asserts.sv */
`timescale 1ns/10ps
module etd_chk(
  input wire core_clk, reset_n, dispatch_req, interrupt_return_instr, save_req, save_32bit,
  input wire io_chk_req, disp_valid_r, shutdown_r, nmi_blocked_r, save_valid_r, io_gp_r,
  input wire [255:0] trap_pend, exec_pend,
  input wire [15:0] interrupt_table_limit, sel_in, io_port,
  input wire [31:0] flags_register, io_map_base, task_state_limit, save_sel_r, save_flags_r,
  input wire [7:0] disp_vector_r, io_gp_vector_r,
  input wire [2:0] disp_cat_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_cat; dispatch_req && |trap_pend && !shutdown_r && &interrupt_table_limit
    |=> disp_valid_r && disp_cat_r == 3'h0; endproperty
  a_cat: assert property (p_cat) else $error("trap not first");
  property p_nmi; nmi_blocked_r && !interrupt_return_instr
    |=> !(disp_valid_r && disp_vector_r == 8'h02 && disp_cat_r == 3'h1); endproperty
  a_nmi: assert property (p_nmi) else $error("nmi while blocked");
  property p_lim; disp_valid_r |-> {3'h0, disp_vector_r, 3'h7} <= $past(interrupt_table_limit);
  endproperty
  a_lim: assert property (p_lim) else $error("entry past limit");
  property p_df; dispatch_req && |exec_pend && !shutdown_r && interrupt_table_limit < 16'h0007
    |=> shutdown_r && !disp_valid_r; endproperty
  a_df: assert property (p_df) else $error("no shutdown");
  property p_sd; shutdown_r |=> shutdown_r && !disp_valid_r; endproperty
  a_sd: assert property (p_sd) else $error("left shutdown");
  property p_gp; io_chk_req && {1'b0, io_map_base} + io_port > {1'b0, task_state_limit}
    |=> io_gp_r && io_gp_vector_r == 8'h0D; endproperty
  a_gp: assert property (p_gp) else $error("io fault missing");
  property p_sel; save_req |=> save_valid_r && save_sel_r == {16'h0000, $past(sel_in)};
  endproperty
  a_sel: assert property (p_sel) else $error("selector word");
  property p_flg; save_req && !save_32bit
    |=> save_flags_r == ($past(flags_register) & 32'h0000FFFF); endproperty
  a_flg: assert property (p_flg) else $error("flags not cut");
  c_disp: cover property (disp_valid_r);
  c_sd: cover property (shutdown_r);
  c_gp: cover property (io_gp_r);
endmodule // etd_chk

/* testbench/etd_src.sv */
`timescale 1ns/10ps
// Source holds its events pending until clr drops them all
module etd_src(
  input wire core_clk,
  input wire fire,
  input wire clr,
  input wire [7:0] vec,
  output logic [255:0] ext_pend
);
  initial ext_pend = '0;
  always @(posedge core_clk) ext_pend <= clr ? '0 : fire ? ext_pend | (256'h1 << vec) : ext_pend;
endmodule // etd_src

/* testbench/test_etd_dispatch.sv */
`timescale 1ns/10ps
module test_etd_dispatch;
  logic core_clk=0, reset_n=0, dispatch_req=0, interrupt_return_instr=0, save_req=0, fire=0;
  logic save_32bit=0, io_chk_req=0, clr=0, virtual_mode_ext_bit=0, v86_mode=0;
  logic [255:0] trap_pend='0, fetch_pend='0, decode_pend='0, exec_pend='0;
  logic [15:0] interrupt_table_limit=16'hFFFF, sel_in=16'h0, io_port=16'h0;
  logic [31:0] redir_bitmap_word=32'h0, flags_register=32'h0, io_map_base=32'h0;
  logic [31:0] task_state_limit=32'h0000E000, save_sel_r, save_flags_r;
  logic [7:0] vec=8'h0, disp_vector_r, io_gp_vector_r;
  logic [2:0] disp_cat_r;
  logic [255:0] ext_pend;
  logic disp_valid_r, disp_redirect_r, shutdown_r, nmi_blocked_r, save_valid_r, io_gp_r;
  int errors=0, comparisons=0, cyc=0;
  etd_src etd_src_inst(.*);
  etd_dispatch etd_dispatch_inst(.*);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc == 2000) begin errors++; give_verdict; end
  task give_verdict;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin errors++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end
  endtask
  task tick; @(posedge core_clk); #1; endtask
  task raise(input logic [7:0] v); vec=v; fire=1; tick; fire=0; endtask
  task drop; clr=1; tick; clr=0; endtask
  task disp(input logic [7:0] v, input logic [2:0] c);
    tick; dispatch_req=1; tick; dispatch_req=0;
    chk(disp_valid_r, 1); chk(disp_vector_r, v); chk(disp_cat_r, c);
  endtask
  task s_prio;
    trap_pend=256'h12; fetch_pend=256'h40; decode_pend=256'h20; exec_pend=256'h8;
    raise(8'h28); raise(8'h21); disp(8'h01, 3'h0);
    trap_pend='0; disp(8'h21, 3'h1);
    drop; disp(8'h06, 3'h2);
    fetch_pend='0; disp(8'h05, 3'h3);
    decode_pend='0; disp(8'h03, 3'h4); exec_pend='0;
  endtask
  task s_nmi;
    raise(8'h02); disp(8'h02, 3'h1); tick; chk(nmi_blocked_r, 1);
    dispatch_req=1; tick; dispatch_req=0; chk(disp_valid_r, 0);
    interrupt_return_instr=1; tick; interrupt_return_instr=0; tick;
    chk(nmi_blocked_r, 0); disp(8'h02, 3'h1); drop;
  endtask
  task s_redir;
    virtual_mode_ext_bit=1; v86_mode=1; redir_bitmap_word=32'h00000020;
    raise(8'h25); disp(8'h25, 3'h1); chk(disp_redirect_r, 1); drop;
  endtask
  task sv(input logic s, input logic [31:0] e);
    save_32bit=s; sel_in=16'hBEEF; flags_register=32'h00021234; save_req=1; tick; save_req=0;
    chk(save_valid_r, 1); chk(save_sel_r, 32'h0000BEEF); chk(save_flags_r, e);
  endtask
  task io(input logic [31:0] b, input logic [15:0] p, input logic e);
    io_map_base=b; io_port=p; io_chk_req=1; tick; io_chk_req=0;
    chk(io_gp_r, e); if (e) chk(io_gp_vector_r, 8'h0D);
  endtask
  task s_lim;
    interrupt_table_limit=16'h0107; raise(8'h20); disp(8'h20, 3'h1); drop;
    redir_bitmap_word=32'h00000002;
    raise(8'h21); disp(8'h08, 3'h1); chk(disp_redirect_r, 0); drop;
    interrupt_table_limit=16'h0006; exec_pend=256'h8; tick; dispatch_req=1; tick; dispatch_req=0;
    chk(shutdown_r, 1); chk(disp_valid_r, 0);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    #1 chk(disp_cat_r, 3'h7); chk(nmi_blocked_r, 0);
    reset_n=1;
    s_prio; s_nmi; s_redir; sv(1, 32'h00021234); sv(0, 32'h00001234);
    io(32'h0000DFFE, 16'h0002, 0); io(32'h0000DFFE, 16'h0003, 1);
    io(32'hFFFFFFFF, 16'h0002, 1);
    s_lim; give_verdict;
  end
endmodule // test_etd_dispatch
bind etd_dispatch etd_chk etd_chk_inst(.*);
